/* File: include/uirp_pkg.sv */
package uirp_pkg;
    // CPU-side register offsets on the plain register port
    localparam logic [3:0] UIRP_OFF_DATA = 4'h5;
    localparam logic [3:0] UIRP_OFF_ADDR_CTRL = 4'h4;
    localparam logic [7:0] UIRP_DATA_RESET = 8'h00;
    // Address/control register fields
    localparam int UIRP_DIR_BIT = 7;
    localparam int UIRP_BUSY_BIT = 6;
    localparam int UIRP_RSVD_BIT = 5;
    localparam logic [4:0] UIRP_OFS_RESET = 5'h00;
    // Controller register offsets
    localparam logic [4:0] UIRP_EP0_BUF = 5'h10;
    localparam logic [4:0] UIRP_EP1_BUF = 5'h11;
    localparam logic [4:0] UIRP_EP2_BUF = 5'h12;
    localparam logic [4:0] UIRP_EP3_BUF = 5'h13;
    localparam logic [4:0] UIRP_SETUP_BUF = 5'h14;
    // Buffer window depth per endpoint buffer register
    localparam int UIRP_BUF_DEPTH = 8;
    typedef enum logic [3:0] {
        UIRP_IDLE = 4'h1,
        UIRP_WAIT_DATA = 4'h2,
        UIRP_READ = 4'h4,
        UIRP_WRITE = 4'h8
    } uirp_state_type;
endpackage

/* File: rtl/uirp_buffer.sv */
`timescale 1ns/1ps
// One controller buffer register: a small byte FIFO-style window
module uirp_buffer
    import uirp_pkg::*;
(
    input wire logic REF_CLK, // System clock
    input wire logic RST_N, // Async reset, active low
    input wire logic wr_en, // Write one byte
    input wire logic rd_en, // Consume one byte
    input wire logic [7:0] wr_data, // Byte to store
    output logic [7:0] rd_data // Byte at the read pointer
);
    logic [7:0] mem_q [UIRP_BUF_DEPTH];
    logic [2:0] wp_q, wp_d, rp_q, rp_d;

    always_comb begin
        wp_d = wr_en ? wp_q + 3'h1 : wp_q;
        rp_d = rd_en ? rp_q + 3'h1 : rp_q;
    end

    // Storage has no reset; contents are undefined until written
    always_ff @(posedge REF_CLK) begin
        if (wr_en) begin
            mem_q[wp_q] <= wr_data;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            wp_q <= 3'h0;
            rp_q <= 3'h0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
        end
    end

    assign rd_data = mem_q[rp_q];
endmodule

/* File: rtl/uirp_top.sv */
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
// Summary of operation
// R1 - Offsets 12h,13h,14h select EP2, EP3, setup
// R2 - Busy set at start, held until done
// R3 - Direction one starts read at offset
// R4 - Direction zero waits for data, then writes
// R5 - Data register resets to zero
// R6 - Data register ignores writes while busy, except the data load that ends the wait for data
// R7 - Data holds write byte, returns read byte
// R8 - Offsets 10h,11h select EP0, EP1
// R9 - Address bit five reads zero, ignores writes
module uirp_top
    import uirp_pkg::*;
(
    input wire logic REF_CLK, // System clock, 10 MHz
    input wire logic RST_N, // Async reset, active low
    input wire logic [3:0] ADDR, // Register port address
    input wire logic [7:0] WDATA, // Register write data
    input wire logic WR, // Write strobe
    input wire logic RD, // Read strobe
    output logic [7:0] RDATA // Read data, cycle after RD
);
    uirp_state_type state_q, state_d;
    logic dir_q, dir_d;
    logic [4:0] ofs_q, ofs_d;
    logic [7:0] data_q, data_d;
    logic [7:0] rdata_q, rdata_d;
    logic [7:0] rd_byte;
    logic busy;
    logic wr_ctrl, wr_data;
    logic [4:0] buf_wr, buf_rd;
    logic [7:0] buf_q [5];
    logic [7:0] oth_q [16], oth_d [16];

    assign busy = (state_q != UIRP_IDLE); // R2
    assign wr_ctrl = WR && (ADDR == UIRP_OFF_ADDR_CTRL) && !busy;
    assign wr_data = WR && (ADDR == UIRP_OFF_DATA) && !busy; // R6

    always_comb begin
        state_d = state_q;
        dir_d = dir_q;
        ofs_d = ofs_q;
        data_d = data_q;
        if (wr_ctrl) begin
            dir_d = WDATA[UIRP_DIR_BIT];
            ofs_d = WDATA[4:0]; // R9
            state_d = WDATA[UIRP_DIR_BIT] ? UIRP_READ : UIRP_WAIT_DATA; // R3
        end
        if (wr_data) begin
            data_d = WDATA; // R7
        end
        case (state_q)
            UIRP_IDLE: begin
            end
            UIRP_WAIT_DATA: begin
                // Write starts only once data has been loaded
                if (WR && (ADDR == UIRP_OFF_DATA)) begin
                    data_d = WDATA; // R4
                    state_d = UIRP_WRITE;
                end
            end
            UIRP_READ: begin
                data_d = rd_byte; // R7
                state_d = UIRP_IDLE;
            end
            UIRP_WRITE: begin
                state_d = UIRP_IDLE;
            end
            default: begin
                state_d = UIRP_IDLE;
            end
        endcase
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_q <= UIRP_IDLE;
            dir_q <= 1'b0;
            ofs_q <= UIRP_OFS_RESET;
            data_q <= UIRP_DATA_RESET; // R5
        end else begin
            state_q <= state_d;
            dir_q <= dir_d;
            ofs_q <= ofs_d;
            data_q <= data_d;
        end
    end

    // Controller register file: buffers at 10h-14h, plain bytes below
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_buf
            assign buf_wr[gi] = (state_q == UIRP_WRITE) && (ofs_q == UIRP_EP0_BUF + 5'(gi));
            assign buf_rd[gi] = (state_q == UIRP_READ) && (ofs_q == UIRP_EP0_BUF + 5'(gi));
            uirp_buffer u_buf (
                .REF_CLK(REF_CLK),
                .RST_N(RST_N),
                .wr_en(buf_wr[gi]),
                .rd_en(buf_rd[gi]),
                .wr_data(data_q),
                .rd_data(buf_q[gi])
            );
        end
    endgenerate

    always_comb begin
        oth_d = oth_q;
        if ((state_q == UIRP_WRITE) && !ofs_q[4]) begin
            oth_d[ofs_q[3:0]] = data_q;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            oth_q <= '{default: 8'h00};
        end else begin
            oth_q <= oth_d;
        end
    end

    always_comb begin
        // Reserved controller offsets 15h-1Fh read zero, writes do nothing
        case (ofs_q)
            UIRP_EP0_BUF: rd_byte = buf_q[0]; // R8
            UIRP_EP1_BUF: rd_byte = buf_q[1]; // R8
            UIRP_EP2_BUF: rd_byte = buf_q[2]; // R1
            UIRP_EP3_BUF: rd_byte = buf_q[3]; // R1
            UIRP_SETUP_BUF: rd_byte = buf_q[4]; // R1
            default: rd_byte = ofs_q[4] ? 8'h00 : oth_q[ofs_q[3:0]];
        endcase
    end

    always_comb begin
        rdata_d = 8'h00;
        if (RD) begin
            if (ADDR == UIRP_OFF_DATA) begin
                rdata_d = data_q;
            end else if (ADDR == UIRP_OFF_ADDR_CTRL) begin
                rdata_d = {dir_q, busy, 1'b0, ofs_q}; // R9
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign RDATA = rdata_q;

    busy_read_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R2
        wr_ctrl && WDATA[UIRP_DIR_BIT] |=> busy ##1 !busy)
        else $error("read did not hold busy for one cycle");
    busy_write_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R2
        (state_q == UIRP_WAIT_DATA) && WR && (ADDR == UIRP_OFF_DATA) |=> busy ##1 !busy)
        else $error("write did not hold busy for one cycle");
    ctrl_lock_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R2
        busy && WR && (ADDR == UIRP_OFF_ADDR_CTRL) |=> $stable(ofs_q) && $stable(dir_q))
        else $error("control changed while busy");
    write_wait_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R4
        (state_q == UIRP_WAIT_DATA) && !WR |=> state_q == UIRP_WAIT_DATA)
        else $error("write began before data was loaded");
    write_launch_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R4
        (state_q == UIRP_WAIT_DATA) && WR && (ADDR == UIRP_OFF_DATA)
        |=> (state_q == UIRP_WRITE) && (data_q == $past(WDATA)))
        else $error("write did not start on data load");
    data_lock_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R6
        (state_q == UIRP_WRITE) |=> $stable(data_q))
        else $error("data changed while busy");
    data_take_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R7
        !busy && WR && (ADDR == UIRP_OFF_DATA) |=> data_q == $past(WDATA))
        else $error("idle data write not taken");
    read_back_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R7
        (state_q == UIRP_READ) |=> data_q == $past(rd_byte))
        else $error("read byte not returned");
    rdata_idle_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R7
        !RD |=> RDATA == 8'h00)
        else $error("read data stood past its cycle");
    rsvd_zero_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R9
        $past(RD) && ($past(ADDR) == UIRP_OFF_ADDR_CTRL) |-> !RDATA[UIRP_RSVD_BIT])
        else $error("reserved bit read as one");
    read_start_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R3
        wr_ctrl && WDATA[UIRP_DIR_BIT] |=> state_q == UIRP_READ)
        else $error("read not started");
    ep2_sel_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R1
        (ofs_q == UIRP_EP2_BUF) |-> (rd_byte == buf_q[2])
        && (buf_wr == ((state_q == UIRP_WRITE) ? 5'h04 : 5'h00)))
        else $error("offset 12h misrouted");
    setup_wr_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R1
        (state_q == UIRP_WRITE) && (ofs_q == UIRP_SETUP_BUF) |-> buf_wr == 5'h10)
        else $error("offset 14h write misrouted");
    rsvd_drop_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R1
        (state_q == UIRP_WRITE) && (ofs_q > UIRP_SETUP_BUF) |-> buf_wr == 5'h00)
        else $error("reserved offset write reached a buffer");
    ep0_sel_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R8
        (ofs_q == UIRP_EP0_BUF) |-> (rd_byte == buf_q[0])
        && (buf_wr == ((state_q == UIRP_WRITE) ? 5'h01 : 5'h00)))
        else $error("offset 10h misrouted");
    ep1_wr_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R8
        (state_q == UIRP_WRITE) && (ofs_q == UIRP_EP1_BUF) |-> buf_wr == 5'h02)
        else $error("offset 11h write misrouted");
endmodule

/* File: tb/uirp_ctrl_model.sv */
`timescale 1ns/1ps
// Controller register file as software sees it; buffer reads consume
module uirp_ctrl_model
    import uirp_pkg::*;
    ;
    logic [7:0] plain_q [16];
    logic [7:0] fifo_q [5][UIRP_BUF_DEPTH];
    int wp_q [5];
    int rp_q [5];
    // What a reset leaves: plain bytes zero, every buffer empty
    function automatic void clear();
        foreach (plain_q[i]) plain_q[i] = 8'h00;
        foreach (wp_q[i]) begin
            wp_q[i] = 0;
            rp_q[i] = 0;
        end
    endfunction
    initial clear();
    // Reserved offsets drop writes and read zero
    function automatic void put(input logic [4:0] ofs, input logic [7:0] d);
        int b;
        b = int'(ofs) - 16;
        if (ofs < 5'h10) begin
            plain_q[ofs[3:0]] = d;
        end else if (ofs < 5'h15) begin
            fifo_q[b][wp_q[b] % UIRP_BUF_DEPTH] = d;
            wp_q[b]++;
        end
    endfunction
    function automatic logic [7:0] get(input logic [4:0] ofs);
        int b;
        logic [7:0] r;
        b = int'(ofs) - 16;
        r = 8'h00;
        if (ofs < 5'h10) begin
            r = plain_q[ofs[3:0]];
        end else if (ofs < 5'h15) begin
            r = fifo_q[b][rp_q[b] % UIRP_BUF_DEPTH];
            rp_q[b]++;
        end
        return r;
    endfunction
endmodule

/* File: tb/usb_indirect_register_port_tb.sv */
`timescale 1ns/1ps
module usb_indirect_register_port_tb;
    import uirp_pkg::*;
    logic ref_clk, rst_n, wr, rd;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, v;
    logic [4:0] bo;
    logic [4:0] pb;
    logic [7:0] db;
    logic [31:0] seed = 32'hAB33;
    int error_cnt = 0;
    int num_checks = 0;
    uirp_top dut_u (.REF_CLK(ref_clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata));
    uirp_ctrl_model model_u ();
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
            error_cnt++;
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic bus_rd(input logic [3:0] a);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    // Three writes with no idle cycle between them
    task automatic b2b(input logic [3:0] a0, input logic [7:0] d0, input logic [3:0] a1,
        input logic [7:0] d1, input logic [3:0] a2, input logic [7:0] d2);
        @(posedge ref_clk);
        addr <= a0;
        wdata <= d0;
        wr <= 1'b1;
        @(posedge ref_clk);
        addr <= a1;
        wdata <= d1;
        @(posedge ref_clk);
        addr <= a2;
        wdata <= d2;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    task automatic wait_idle();
        for (int n = 0; n < 8; n++) begin
            bus_rd(UIRP_OFF_ADDR_CTRL);
            if (v[UIRP_BUSY_BIT] === 1'b0) return;
        end
        check({7'h00, v[UIRP_BUSY_BIT]}, 8'h00);
        print_verdict();
    endtask
    // Reserved bit set on purpose; a second control write lands while busy
    task automatic do_write(input logic [4:0] o, input logic [7:0] d);
        bus_wr(UIRP_OFF_ADDR_CTRL, {3'h1, o});
        bus_rd(UIRP_OFF_ADDR_CTRL);
        check(v, {3'h2, o});
        bus_wr(UIRP_OFF_ADDR_CTRL, {3'h4, ~o});
        bus_wr(UIRP_OFF_DATA, d);
        model_u.put(o, d);
        wait_idle();
        check(v, {3'h0, o});
        bus_rd(UIRP_OFF_DATA);
        check(v, d);
    endtask
    task automatic do_read(input logic [4:0] o);
        bus_wr(UIRP_OFF_ADDR_CTRL, {3'h4, o});
        wait_idle();
        check(v, {3'h4, o});
        bus_rd(UIRP_OFF_DATA);
        check(v, model_u.get(o));
    endtask
    initial begin
        rst_n = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        bus_rd(UIRP_OFF_DATA);
        check(v, UIRP_DATA_RESET);
        bus_rd(UIRP_OFF_ADDR_CTRL);
        check(v, 8'h00);
        for (int o = 0; o < 32; o++) begin
            seed = xs(seed);
            do_write(o[4:0], seed[7:0]);
            do_read(o[4:0]);
        end
        // Corners on a plain byte: strobes with no gap between them
        seed = xs(seed);
        pb = {1'b0, seed[3:0]};
        db = seed[15:8];
        b2b(UIRP_OFF_ADDR_CTRL, {3'h0, pb}, UIRP_OFF_DATA, db, UIRP_OFF_DATA, ~db);
        model_u.put(pb, db);
        wait_idle();
        bus_rd(UIRP_OFF_DATA);
        check(v, db);
        b2b(UIRP_OFF_ADDR_CTRL, {3'h4, pb}, UIRP_OFF_DATA, ~db, UIRP_OFF_ADDR_CTRL, {3'h4, pb});
        wait_idle();
        bus_rd(UIRP_OFF_DATA);
        check(v, model_u.get(pb));
        @(posedge ref_clk);
        addr <= UIRP_OFF_ADDR_CTRL;
        wdata <= {3'h4, pb};
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 v = rdata;
        check(v, {3'h6, pb});
        wait_idle();
        bus_rd(UIRP_OFF_DATA);
        check(v, model_u.get(pb));
        // Reset in mid-run clears the data register and the controller side
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        model_u.clear();
        bus_rd(UIRP_OFF_DATA);
        check(v, UIRP_DATA_RESET);
        bus_rd(UIRP_OFF_ADDR_CTRL);
        check(v, 8'h00);
        do_read(pb);
        // Fill a random buffer to its full depth, then drain it in order
        for (int r = 0; r < 3; r++) begin
            seed = xs(seed);
            bo = UIRP_EP0_BUF + {3'h0, seed[1:0]};
            for (int k = 0; k < UIRP_BUF_DEPTH; k++) begin
                seed = xs(seed);
                do_write(bo, seed[7:0]);
            end
            for (int k = 0; k < UIRP_BUF_DEPTH; k++) do_read(bo);
        end
        print_verdict();
    end
endmodule
